// *** hdl/crma_interp.sv ***
// Device end: decodes configuration messages and performs register access
`timescale 1ns/100ps
module crma_interp (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // Channel destination of the incoming stream
    input  wire logic [15:0] DEST_SEL,
    // Token link
    crma_link_if.interp      LINK,
    // Tile register port; REG_NUM and REG_WDATA also serve the node port
    output logic             TILE_WR,
    output logic             TILE_RD,
    output logic [15:0]      REG_NUM,
    output logic [31:0]      REG_WDATA,
    input  wire logic [31:0] TILE_RDATA,
    input  wire logic        TILE_OK,
    // Node register port
    output logic             NODE_WR,
    output logic             NODE_RD,
    input  wire logic [31:0] NODE_RDATA,
    input  wire logic        NODE_OK
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        crma_pkg::crma_state_e st;
        logic                  is_wr;
        logic                  is_node;
        logic                  ok;
        logic [1:0]            cnt;
        logic [23:0]           reply;
        logic [15:0]           regn;
        logic [31:0]           data;
        logic                  req_ready;
        logic                  rsp_valid;
        logic                  rsp_ctrl;
        logic [7:0]            rsp_tok;
        logic                  twr;
        logic                  trd;
        logic                  nwr;
        logic                  nrd;
    } crma_int_s;

    crma_int_s cur_ff;
    crma_int_s nxt_cur;
    logic      take;
    logic      sent;
    logic      acc_ok;

    assign take   = LINK.req_valid & cur_ff.req_ready;
    assign sent   = cur_ff.rsp_valid & LINK.rsp_ready;
    assign acc_ok = cur_ff.is_node ? NODE_OK : TILE_OK;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_cur     = cur_ff;
        nxt_cur.twr = 1'b0;
        nxt_cur.trd = 1'b0;
        nxt_cur.nwr = 1'b0;
        nxt_cur.nrd = 1'b0;
        case (cur_ff.st)
            crma_pkg::ST_IDLE:
            begin
                nxt_cur.req_ready = 1'b1;
                if (take && LINK.req_ctrl)
                begin
                    nxt_cur.cnt     = 2'(crma_pkg::REPLY_BYTES - 1);
                    nxt_cur.is_node = (DEST_SEL == crma_pkg::DEST_NODE);
                    if ((LINK.req_tok == crma_pkg::TOK_WRITE ||
                         LINK.req_tok == crma_pkg::TOK_READ) &&
                        (DEST_SEL == crma_pkg::DEST_TILE ||
                         DEST_SEL == crma_pkg::DEST_NODE))
                    begin
                        nxt_cur.is_wr = (LINK.req_tok == crma_pkg::TOK_WRITE);
                        nxt_cur.st    = crma_pkg::ST_REPLY;
                    end
                end
            end
            crma_pkg::ST_REPLY:
            begin
                if (take)
                begin
                    nxt_cur.reply = {cur_ff.reply[15:0], LINK.req_tok};
                    nxt_cur.cnt   = cur_ff.cnt - 2'h1;
                    if (cur_ff.cnt == crma_pkg::CNT_ZERO)
                    begin
                        nxt_cur.cnt = 2'(crma_pkg::REG_BYTES - 1);
                        nxt_cur.st  = crma_pkg::ST_REG;
                    end
                end
            end
            crma_pkg::ST_REG:
            begin
                if (take)
                begin
                    nxt_cur.regn = {cur_ff.regn[7:0], LINK.req_tok};
                    nxt_cur.cnt  = cur_ff.cnt - 2'h1;
                    if (cur_ff.cnt == crma_pkg::CNT_ZERO)
                    begin
                        nxt_cur.cnt = 2'(crma_pkg::DATA_BYTES - 1);
                        nxt_cur.st  = cur_ff.is_wr ? crma_pkg::ST_DATA : crma_pkg::ST_END;
                    end
                end
            end
            crma_pkg::ST_DATA:
            begin
                if (take)
                begin
                    nxt_cur.data = {cur_ff.data[23:0], LINK.req_tok};
                    nxt_cur.cnt  = cur_ff.cnt - 2'h1;
                    if (cur_ff.cnt == crma_pkg::CNT_ZERO)
                        nxt_cur.st = crma_pkg::ST_END;
                end
            end
            crma_pkg::ST_END:
            begin
                if (take)
                begin
                    nxt_cur.req_ready = 1'b0;
                    if (LINK.req_ctrl && LINK.req_tok == crma_pkg::TOK_END)
                    begin
                        nxt_cur.twr = cur_ff.is_wr & ~cur_ff.is_node;
                        nxt_cur.nwr = cur_ff.is_wr & cur_ff.is_node;
                        nxt_cur.trd = ~cur_ff.is_wr & ~cur_ff.is_node;
                        nxt_cur.nrd = ~cur_ff.is_wr & cur_ff.is_node;
                        nxt_cur.st  = crma_pkg::ST_ACC;
                    end
                    else
                    begin
                        // Malformed message: refuse without access
                        nxt_cur.ok        = 1'b0;
                        nxt_cur.rsp_valid = 1'b1;
                        nxt_cur.rsp_ctrl  = 1'b1;
                        nxt_cur.rsp_tok   = crma_pkg::TOK_NACK;
                        nxt_cur.st        = crma_pkg::ST_HEAD;
                    end
                end
            end
            crma_pkg::ST_ACC:
            begin
                // Register port answers in the same cycle as the strobe
                nxt_cur.ok        = acc_ok;
                if (!cur_ff.is_wr)
                    nxt_cur.data = cur_ff.is_node ? NODE_RDATA : TILE_RDATA;
                nxt_cur.rsp_valid = 1'b1;
                nxt_cur.rsp_ctrl  = 1'b1;
                nxt_cur.rsp_tok   = acc_ok ? crma_pkg::TOK_ACK : crma_pkg::TOK_NACK;
                nxt_cur.cnt       = 2'(crma_pkg::DATA_BYTES - 1);
                nxt_cur.st        = crma_pkg::ST_HEAD;
            end
            crma_pkg::ST_HEAD:
            begin
                if (sent)
                begin
                    if (cur_ff.ok && !cur_ff.is_wr)
                    begin
                        nxt_cur.rsp_ctrl = 1'b0;
                        nxt_cur.rsp_tok  = cur_ff.data[31:24];
                        nxt_cur.st       = crma_pkg::ST_RDAT;
                    end
                    else
                    begin
                        nxt_cur.rsp_tok = crma_pkg::TOK_END;
                        nxt_cur.st      = crma_pkg::ST_TAIL;
                    end
                end
            end
            crma_pkg::ST_RDAT:
            begin
                if (sent)
                begin
                    nxt_cur.data = {cur_ff.data[23:0], 8'h00};
                    nxt_cur.cnt  = cur_ff.cnt - 2'h1;
                    if (cur_ff.cnt == crma_pkg::CNT_ZERO)
                    begin
                        nxt_cur.rsp_ctrl = 1'b1;
                        nxt_cur.rsp_tok  = crma_pkg::TOK_END;
                        nxt_cur.st       = crma_pkg::ST_TAIL;
                    end
                    else
                        nxt_cur.rsp_tok = cur_ff.data[23:16];
                end
            end
            crma_pkg::ST_TAIL:
            begin
                if (sent)
                begin
                    nxt_cur.rsp_valid = 1'b0;
                    nxt_cur.req_ready = 1'b1;
                    nxt_cur.st        = crma_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_cur.st = crma_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign LINK.req_ready = cur_ff.req_ready;
    assign LINK.rsp_valid = cur_ff.rsp_valid;
    assign LINK.rsp_ctrl  = cur_ff.rsp_ctrl;
    assign LINK.rsp_tok   = cur_ff.rsp_tok;
    assign LINK.rsp_dest  = cur_ff.reply;
    assign TILE_WR        = cur_ff.twr;
    assign TILE_RD        = cur_ff.trd;
    assign NODE_WR        = cur_ff.nwr;
    assign NODE_RD        = cur_ff.nrd;
    assign REG_NUM        = cur_ff.regn;
    assign REG_WDATA      = cur_ff.data;
endmodule : crma_interp

// *** hdl/crma_link_if.sv ***
// Token link between a requesting channel end and the interpreter
`timescale 1ns/100ps
interface crma_link_if;
    // Request path: requester to interpreter
    logic        req_valid;
    logic        req_ready;
    logic        req_ctrl;
    logic [7:0]  req_tok;
    // Reply path: interpreter to requester
    logic        rsp_valid;
    logic        rsp_ready;
    logic        rsp_ctrl;
    logic [7:0]  rsp_tok;
    logic [23:0] rsp_dest;
    modport requester (
        output req_valid, req_ctrl, req_tok, rsp_ready,
        input  req_ready, rsp_valid, rsp_ctrl, rsp_tok, rsp_dest
    );
    modport interp (
        input  req_valid, req_ctrl, req_tok, rsp_ready,
        output req_ready, rsp_valid, rsp_ctrl, rsp_tok, rsp_dest
    );
endinterface : crma_link_if

// *** hdl/crma_pkg.sv ***
// Shared constants and types of the configuration message access block
package crma_pkg;
    // ------------------------------------------------------------------
    // Tokens
    // ------------------------------------------------------------------
    localparam logic [7:0]  TOK_WRITE   = 8'hC0;
    localparam logic [7:0]  TOK_READ    = 8'hC1;
    localparam logic [7:0]  TOK_END     = 8'h01;
    localparam logic [7:0]  TOK_ACK     = 8'h03;
    localparam logic [7:0]  TOK_NACK    = 8'h04;
    // ------------------------------------------------------------------
    // Destination selectors and field widths
    // ------------------------------------------------------------------
    localparam logic [15:0] DEST_TILE   = 16'hC20C;
    localparam logic [15:0] DEST_NODE   = 16'hC30C;
    localparam int          REPLY_BYTES = 3;
    localparam int          REG_BYTES   = 2;
    localparam int          DATA_BYTES  = 4;
    localparam logic [1:0]  CNT_ZERO    = 2'h0;
    // ------------------------------------------------------------------
    // Interpreter states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_REPLY = 4'h1,
        ST_REG   = 4'h2,
        ST_DATA  = 4'h3,
        ST_END   = 4'h4,
        ST_ACC   = 4'h5,
        ST_HEAD  = 4'h6,
        ST_RDAT  = 4'h7,
        ST_TAIL  = 4'h8,
        ST_SKIP  = 4'h9
    } crma_state_e;
endpackage : crma_pkg

// *** hdl/crma_requester.sv ***
// Requester end: sends one configuration message and collects the reply
`timescale 1ns/100ps
module crma_requester (
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    // User command
    input  wire logic        CMD_GO,
    input  wire logic        CMD_WRITE,
    input  wire logic        CMD_NODE,
    input  wire logic [15:0] CMD_ID,
    input  wire logic [23:0] CMD_REPLY,
    input  wire logic [15:0] CMD_REG,
    input  wire logic [31:0] CMD_WDATA,
    output logic             CMD_BUSY,
    // Channel destination
    output logic [31:0]      DEST_OUT,
    // Result
    output logic             DONE,
    output logic             OK,
    output logic [31:0]      RDATA,
    // Token link
    crma_link_if.requester   LINK
);
    typedef struct packed {
        logic        busy;
        logic        sending;
        logic [3:0]  idx;
        logic [3:0]  last;
        logic [71:0] msg;
        logic [31:0] dest;
        logic        got_head;
        logic        ok;
        logic [31:0] rdata;
        logic        done;
    } crma_req_s;

    crma_req_s cur_ff;
    crma_req_s nxt_cur;
    logic      push;
    logic      pop;

    assign push = cur_ff.sending & LINK.req_ready;
    assign pop  = LINK.rsp_valid;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_cur      = cur_ff;
        nxt_cur.done = 1'b0;
        if (!cur_ff.busy && CMD_GO)
        begin
            nxt_cur.busy     = 1'b1;
            nxt_cur.sending  = 1'b1;
            nxt_cur.idx      = 4'h0;
            nxt_cur.got_head = 1'b0;
            nxt_cur.dest     = {CMD_ID, CMD_NODE ? crma_pkg::DEST_NODE
                                                 : crma_pkg::DEST_TILE};
            nxt_cur.msg      = {CMD_REPLY, CMD_REG, CMD_WDATA};
            nxt_cur.last     = CMD_WRITE ? 4'hA : 4'h6;
            nxt_cur.ok       = CMD_WRITE;
        end
        if (push)
        begin
            nxt_cur.idx = cur_ff.idx + 4'h1;
            if (cur_ff.idx != 4'h0)
                nxt_cur.msg = {cur_ff.msg[63:0], 8'h00};
            if (cur_ff.idx == cur_ff.last)
                nxt_cur.sending = 1'b0;
        end
        if (pop && cur_ff.busy)
        begin
            if (LINK.rsp_ctrl && LINK.rsp_tok == crma_pkg::TOK_END)
            begin
                nxt_cur.busy = 1'b0;
                nxt_cur.done = 1'b1;
            end
            else if (LINK.rsp_ctrl)
            begin
                nxt_cur.got_head = 1'b1;
                nxt_cur.ok       = (LINK.rsp_tok == crma_pkg::TOK_ACK);
            end
            else
                nxt_cur.rdata = {cur_ff.rdata[23:0], LINK.rsp_tok};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
            cur_ff <= '0;
        else
            cur_ff <= nxt_cur;
    end

    // ------------------------------------------------------------------
    // Link drive: first token is a control token, last is the end token
    // ------------------------------------------------------------------
    logic is_wr_msg;
    assign is_wr_msg      = (cur_ff.last == 4'hA);
    assign LINK.req_valid = cur_ff.sending;
    assign LINK.req_ctrl  = (cur_ff.idx == 4'h0) || (cur_ff.idx == cur_ff.last);
    assign LINK.req_tok   = (cur_ff.idx == 4'h0) ?
                            (is_wr_msg ? crma_pkg::TOK_WRITE : crma_pkg::TOK_READ) :
                            (cur_ff.idx == cur_ff.last) ? crma_pkg::TOK_END :
                            cur_ff.msg[71:64];
    assign LINK.rsp_ready = 1'b1;
    assign CMD_BUSY       = cur_ff.busy;
    assign DEST_OUT       = cur_ff.dest;
    assign DONE           = cur_ff.done;
    assign OK             = cur_ff.ok & cur_ff.got_head;
    assign RDATA          = cur_ff.rdata;
endmodule : crma_requester

// *** testbench/crma_link_props.sv ***
// Concurrent checks on the token link between requester and interpreter
`timescale 1ns/100ps
module crma_link_props (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST_B,
    // Request path
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_ctrl,
    input wire logic [7:0]  req_tok,
    // Reply path
    input wire logic        rsp_valid,
    input wire logic        rsp_ready,
    input wire logic        rsp_ctrl,
    input wire logic [7:0]  rsp_tok,
    input wire logic [23:0] rsp_dest
);
    logic        in_ff;
    logic        wr_ff;
    logic        ack_ff;
    logic [3:0]  cnt_ff;
    logic [2:0]  ridx_ff;
    logic [23:0] id_ff;
    logic        hdr;
    assign hdr = req_ctrl && (req_tok == crma_pkg::TOK_WRITE || req_tok == crma_pkg::TOK_READ);
    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            in_ff   <= 1'b0;
            wr_ff   <= 1'b0;
            ack_ff  <= 1'b0;
            cnt_ff  <= 4'h0;
            ridx_ff <= 3'h0;
            id_ff   <= 24'h000000;
        end
        else
        begin
            if (req_valid && req_ready)
            begin
                if (hdr)
                begin
                    in_ff  <= 1'b1;
                    wr_ff  <= (req_tok == crma_pkg::TOK_WRITE);
                    cnt_ff <= 4'h0;
                end
                else if (req_ctrl)
                    in_ff <= 1'b0;
                else if (in_ff)
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff < 4'h3)
                        id_ff <= {id_ff[15:0], req_tok};
                end
            end
            if (rsp_valid && rsp_ready)
            begin
                ridx_ff <= (rsp_ctrl && rsp_tok == crma_pkg::TOK_END) ? 3'h0 : ridx_ff + 3'h1;
                if (ridx_ff == 3'h0)
                    ack_ff <= (rsp_tok == crma_pkg::TOK_ACK);
            end
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    sequence req_end_s;
        req_valid && req_ready && req_ctrl && req_tok == crma_pkg::TOK_END;
    endsequence
    sequence rsp_end_s;
        rsp_valid && rsp_ctrl && rsp_tok == crma_pkg::TOK_END;
    endsequence
    wr_len_a: assert property ((in_ff && wr_ff) ##0 req_end_s |-> cnt_ff == 4'h9)
        else $error("write request length wrong");
    rd_len_a: assert property ((in_ff && !wr_ff) ##0 req_end_s |-> cnt_ff == 4'h5)
        else $error("read request length wrong");
    hold_ready_a: assert property (req_end_s |=> !req_ready [*3])
        else $error("request accepted during reply");
    reply_head_a: assert property (rsp_valid && ridx_ff == 3'h0 |-> rsp_ctrl &&
        (rsp_tok == crma_pkg::TOK_ACK || rsp_tok == crma_pkg::TOK_NACK))
        else $error("reply head not ack or nack");
    nack_end_a: assert property (rsp_valid && ridx_ff == 3'h1 && !ack_ff |-> rsp_end_s)
        else $error("nack not followed by end");
    wr_ack_end_a: assert property (rsp_valid && ridx_ff == 3'h1 && ack_ff && wr_ff |-> rsp_end_s)
        else $error("write ack not followed by end");
    rd_data_a: assert property (rsp_valid && ack_ff && !wr_ff && ridx_ff inside {[3'h1:3'h4]}
        |-> !rsp_ctrl)
        else $error("read data token marked control");
    rd_end_a: assert property (rsp_valid && ack_ff && !wr_ff && ridx_ff == 3'h5 |-> rsp_end_s)
        else $error("read reply not closed after data");
    reply_dest_a: assert property (rsp_valid |-> rsp_dest == id_ff && !in_ff)
        else $error("reply sent to wrong channel end");
endmodule : crma_link_props

// *** testbench/tb_top.sv ***
// Self-checking bench joining requester and interpreter over the token link
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        CORE_CLK, RST_B, CMD_GO, CMD_WRITE, CMD_NODE, CMD_BUSY, DONE, OK;
    logic        TILE_OK, NODE_OK, TILE_WR, TILE_RD, NODE_WR, NODE_RD;
    logic [15:0] CMD_ID, CMD_REG, REG_NUM, num_seen;
    logic [23:0] CMD_REPLY, dest_seen;
    logic [31:0] CMD_WDATA, TILE_RDATA, NODE_RDATA, DEST_OUT, RDATA, REG_WDATA, wd_seen;
    logic [3:0]  stb_seen;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;
    crma_link_if link ();
    crma_requester i_crma_requester (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CMD_GO(CMD_GO),
        .CMD_WRITE(CMD_WRITE), .CMD_NODE(CMD_NODE), .CMD_ID(CMD_ID), .CMD_REPLY(CMD_REPLY),
        .CMD_REG(CMD_REG), .CMD_WDATA(CMD_WDATA), .CMD_BUSY(CMD_BUSY), .DEST_OUT(DEST_OUT),
        .DONE(DONE), .OK(OK), .RDATA(RDATA), .LINK(link));
    crma_interp i_crma_interp (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .DEST_SEL(DEST_OUT[15:0]),
        .LINK(link), .TILE_WR(TILE_WR), .TILE_RD(TILE_RD), .REG_NUM(REG_NUM),
        .REG_WDATA(REG_WDATA), .TILE_RDATA(TILE_RDATA), .TILE_OK(TILE_OK), .NODE_WR(NODE_WR),
        .NODE_RD(NODE_RD), .NODE_RDATA(NODE_RDATA), .NODE_OK(NODE_OK));
    crma_link_props i_crma_link_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
        .req_valid(link.req_valid), .req_ready(link.req_ready), .req_ctrl(link.req_ctrl),
        .req_tok(link.req_tok), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
        .rsp_ctrl(link.rsp_ctrl), .rsp_tok(link.rsp_tok), .rsp_dest(link.rsp_dest));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One message: even k writes, bit 1 xor bit 2 picks the node, bit 2 makes it fail
    task automatic run_op(input int i);
        logic [2:0] k;
        logic       wr;
        logic       nd;
        logic       ok;
        k = i[2:0];
        wr = !k[0];
        nd = k[1] ^ k[2];
        ok = !k[2];
        for (int n = 0; n < 50 && CMD_BUSY !== 1'b0; n++)
            @(negedge CORE_CLK);
        CMD_WRITE = wr;
        CMD_NODE = nd;
        CMD_ID = {13'h0002, k};
        CMD_REPLY = {8'h5A, 5'h00, k, 8'hC3};
        CMD_REG = {8'h01, 5'h00, k};
        CMD_WDATA = {8'hA5, 21'h000000, k};
        TILE_RDATA = {8'h7E, 21'h000000, k};
        NODE_RDATA = {8'h3C, 21'h000000, k};
        TILE_OK = ok ^ nd;
        NODE_OK = ok;
        CMD_GO = 1'b1;
        @(negedge CORE_CLK);
        CMD_GO = 1'b0;
        for (int n = 0; n < 100 && DONE !== 1'b1; n++)
            @(negedge CORE_CLK);
        chk({31'h00000000, DONE}, 32'h00000001);
        chk({31'h00000000, OK}, {31'h00000000, ok});
        chk({28'h0000000, stb_seen}, {28'h0000000, 4'h1 << {nd, !wr}});
        chk({16'h0000, num_seen}, {16'h0000, CMD_REG});
        if (wr)
            chk(wd_seen, CMD_WDATA);
        if (!wr && ok)
            chk(RDATA, nd ? NODE_RDATA : TILE_RDATA);
        chk(DEST_OUT, {CMD_ID, nd ? 16'hC30C : 16'hC20C});
        chk({8'h00, dest_seen}, {8'h00, CMD_REPLY});
    endtask : run_op
    // ------------------------------------------------------------------
    // Register port capture and timeout
    // ------------------------------------------------------------------
    always @(posedge CORE_CLK)
    begin
        cycles <= cycles + 1;
        if (CMD_GO)
            stb_seen <= 4'h0;
        else if (TILE_WR || TILE_RD || NODE_WR || NODE_RD)
            stb_seen <= stb_seen | {NODE_RD, NODE_WR, TILE_RD, TILE_WR};
        if (TILE_WR || TILE_RD || NODE_WR || NODE_RD)
        begin
            num_seen <= REG_NUM;
            wd_seen <= REG_WDATA;
        end
        if (link.rsp_valid)
            dest_seen <= link.rsp_dest;
        if (cycles == 3000)
        begin
            err_total++;
            finish_test();
        end
    end
    // ------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    initial
    begin
        RST_B = 1'b0;
        CMD_GO = 1'b0;
        CMD_WRITE = 1'b0;
        CMD_NODE = 1'b0;
        CMD_ID = 16'h0000;
        CMD_REPLY = 24'h000000;
        CMD_REG = 16'h0000;
        CMD_WDATA = 32'h00000000;
        TILE_RDATA = 32'h00000000;
        NODE_RDATA = 32'h00000000;
        TILE_OK = 1'b0;
        NODE_OK = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        RST_B = 1'b1;
        for (int i = 0; i < 8; i++)
            run_op(i);
        finish_test();
    end
endmodule : tb_top
